//--- shared/pif_pkg.sv
// Purpose: constants and types shared by the peripheral interrupt flag bank
// Assumes: 32-bit apb data, 8-bit byte addresses, one register per aligned word
// Notes: all registers reset to zero

`default_nettype none

package pif_pkg;

    // ==========================================================
    // apb register map (byte addresses)
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_CCP_MODE = 8'h0C;
    localparam logic [7:0] ADDR_SSP_CTRL = 8'h10;

    // ==========================================================
    // flag register bit positions
    localparam int BIT_PARALLEL_PORT = 7;
    localparam int BIT_CONVERSION_DONE = 6;
    localparam int BIT_RECEIVE_FULL = 5;
    localparam int BIT_TRANSMIT_EMPTY = 4;
    localparam int BIT_SYNC_SERIAL = 3;
    localparam int BIT_CAPTURE_COMPARE = 2;
    localparam int FLAG_W = 8;

    // writable flag vector order: {parallel, conversion, sync serial, capture}
    localparam int WFLAG_W = 4;
    localparam logic [WFLAG_W-1:0] WFLAG_RESET = 4'h0;

    // ==========================================================
    // event status / mask bit positions
    localparam int EV_PARALLEL_PORT = 0;
    localparam int EV_CONVERSION_DONE = 1;
    localparam int EV_RECEIVE_FULL = 2;
    localparam int EV_TRANSMIT_EMPTY = 3;
    localparam int EV_SYNC_SERIAL = 4;
    localparam int EV_CAPTURE_COMPARE = 5;
    localparam int EV_W = 6;
    localparam logic [EV_W-1:0] EV_RESET = 6'h00;

    // ==========================================================
    // ssp control field positions
    localparam int SSP_MODE_LSB = 0;
    localparam int SSP_MULTI_MASTER = 2;
    localparam int SSP_CTRL_W = 3;
    localparam logic [SSP_CTRL_W-1:0] SSP_CTRL_RESET = 3'h0;

    // ==========================================================
    // mode encodings
    typedef enum logic [1:0] {
        PIF_CCP_OFF = 2'b00,
        PIF_CCP_CAPTURE = 2'b01,
        PIF_CCP_COMPARE = 2'b10,
        PIF_CCP_PWM = 2'b11
    } pif_ccp_mode_t;

    typedef enum logic [1:0] {
        PIF_SSP_OFF = 2'b00,
        PIF_SSP_SPI = 2'b01,
        PIF_SSP_I2C_MASTER = 2'b10,
        PIF_SSP_RSVD = 2'b11
    } pif_ssp_mode_t;

endpackage

`default_nettype wire

//--- design/pif_sticky_bits.sv
// Purpose: vector of sticky bits, hardware set wins over software load
// Assumes: set and load are synchronous to clk
// Notes: load writes load_val, so w1c is load with load_val zero

`timescale 1ns/1ps
`default_nettype none

module pif_sticky_bits #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic [W-1:0] set, // hardware set, per bit
    input wire logic [W-1:0] load, // software load enable, per bit
    input wire logic [W-1:0] load_val, // software load value
    output logic [W-1:0] q // current bits
);

    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // set beats a same-cycle load
    always_comb begin
        q_next = set | (load & load_val) | (~load & q_reg);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= RESET_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule

`default_nettype wire

//--- design/pif_flag_bank.sv
// Purpose: first bank of peripheral interrupt flags with an apb slave
// Assumes: all peripheral inputs synchronous to pclk, events one cycle wide
// Notes: flags set whatever any enable says; irq output uses its own mask

`timescale 1ns/1ps
`default_nettype none

module pif_flag_bank (
    input wire logic pclk, // apb clock, 25 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, 1 = write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic psp_access_done, // parallel slave port read/write finished
    input wire logic adc_conv_done, // conversion completed
    input wire logic rx_buf_full, // serial receive buffer holds data
    input wire logic tx_buf_empty, // serial transmit buffer is empty
    input wire logic spi_xfer_done, // spi transmission/reception took place
    input wire logic i2c_byte_done, // i2c byte transmitted or received
    input wire logic i2c_seq_done, // own start/stop/restart/ack completed
    input wire logic i2c_bus_start, // start seen on the i2c bus
    input wire logic i2c_bus_stop, // stop seen on the i2c bus
    input wire logic i2c_port_idle, // i2c port idle
    input wire logic ccp_capture_event, // timer value captured
    input wire logic ccp_compare_match, // timer matched compare value
    output logic [7:0] peripheral_irq_flags_a, // flag bank value
    output logic irq // level interrupt, unmasked event pending
);

    // ==========================================================
    // declarations
    logic ready_reg;
    logic err_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    logic rx_full_reg;
    logic tx_empty_reg;
    logic [pif_pkg::EV_W-1:0] mask_reg;
    logic [1:0] ccp_mode_reg;
    logic [pif_pkg::SSP_CTRL_W-1:0] ssp_ctrl_reg;

    logic setup_phase;
    logic wr_done;
    logic addr_hit;
    logic [31:0] rd_data;

    logic wr_flags;
    logic wr_status;
    logic wr_mask;
    logic wr_ccp_mode;
    logic wr_ssp_ctrl;

    logic parallel_port_set;
    logic conversion_done_set;
    logic sync_serial_set;
    logic capture_compare_set;
    logic receive_full_rise;
    logic transmit_empty_rise;

    logic [1:0] ssp_mode;
    logic ssp_multi_master;

    logic [pif_pkg::WFLAG_W-1:0] wflag_set;
    logic [pif_pkg::WFLAG_W-1:0] wflag_load;
    logic [pif_pkg::WFLAG_W-1:0] wflag_val;
    logic [pif_pkg::WFLAG_W-1:0] wflag_q;

    logic [pif_pkg::EV_W-1:0] ev_set;
    logic [pif_pkg::EV_W-1:0] ev_clear;
    logic [pif_pkg::EV_W-1:0] status_q;

    logic [7:0] flags_now;

    // ==========================================================
    // apb decode
    assign setup_phase = psel && !penable;
    assign wr_done = psel && penable && pwrite && ready_reg;

    always_comb begin
        addr_hit = 1'b1;
        rd_data = 32'h0000_0000;
        case (paddr)
            pif_pkg::ADDR_FLAGS: begin
                rd_data[7:0] = flags_now;
            end
            pif_pkg::ADDR_STATUS: begin
                rd_data[pif_pkg::EV_W-1:0] = status_q;
            end
            pif_pkg::ADDR_MASK: begin
                rd_data[pif_pkg::EV_W-1:0] = mask_reg;
            end
            pif_pkg::ADDR_CCP_MODE: begin
                rd_data[1:0] = ccp_mode_reg;
            end
            pif_pkg::ADDR_SSP_CTRL: begin
                rd_data[pif_pkg::SSP_CTRL_W-1:0] = ssp_ctrl_reg;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    assign wr_flags = wr_done && !err_reg && (paddr == pif_pkg::ADDR_FLAGS);
    assign wr_status = wr_done && !err_reg && (paddr == pif_pkg::ADDR_STATUS);
    assign wr_mask = wr_done && !err_reg && (paddr == pif_pkg::ADDR_MASK);
    assign wr_ccp_mode = wr_done && !err_reg && (paddr == pif_pkg::ADDR_CCP_MODE);
    assign wr_ssp_ctrl = wr_done && !err_reg && (paddr == pif_pkg::ADDR_SSP_CTRL);

    // ==========================================================
    // apb answer: ready in the first access cycle, data caught at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= setup_phase;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_reg <= 1'b0;
        end else if (setup_phase) begin
            err_reg <= !addr_hit;
        end else if (ready_reg) begin
            err_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            rdata_reg <= rd_data;
        end else if (ready_reg) begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign pready = ready_reg;
    assign pslverr = err_reg;
    assign prdata = rdata_reg;

    // ==========================================================
    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= pif_pkg::EV_RESET;
        end else if (wr_mask) begin
            mask_reg <= pwdata[pif_pkg::EV_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccp_mode_reg <= pif_pkg::PIF_CCP_OFF;
        end else if (wr_ccp_mode) begin
            ccp_mode_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ssp_ctrl_reg <= pif_pkg::SSP_CTRL_RESET;
        end else if (wr_ssp_ctrl) begin
            ssp_ctrl_reg <= pwdata[pif_pkg::SSP_CTRL_W-1:0];
        end
    end

    assign ssp_mode = ssp_ctrl_reg[pif_pkg::SSP_MODE_LSB +: 2];
    assign ssp_multi_master = ssp_ctrl_reg[pif_pkg::SSP_MULTI_MASTER];

    // ==========================================================
    // flag set conditions, no enable gates them
    // no enable gating
    assign parallel_port_set = psp_access_done;

    assign conversion_done_set = adc_conv_done;

    always_comb begin
        sync_serial_set = 1'b0;
        case (ssp_mode)
            pif_pkg::PIF_SSP_SPI: begin
                sync_serial_set = spi_xfer_done;
            end
            pif_pkg::PIF_SSP_I2C_MASTER: begin
                sync_serial_set = i2c_byte_done || i2c_seq_done;
                if (ssp_multi_master && i2c_port_idle && (i2c_bus_start || i2c_bus_stop)) begin
                    sync_serial_set = 1'b1;
                end
            end
            default: begin
                sync_serial_set = 1'b0;
            end
        endcase
    end

    always_comb begin
        capture_compare_set = 1'b0;
        case (ccp_mode_reg)
            pif_pkg::PIF_CCP_CAPTURE: begin
                capture_compare_set = ccp_capture_event;
            end
            pif_pkg::PIF_CCP_COMPARE: begin
                capture_compare_set = ccp_compare_match;
            end
            pif_pkg::PIF_CCP_PWM: begin
                capture_compare_set = 1'b0;
            end
            default: begin
                capture_compare_set = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // writable flags: sticky, cleared or loaded only by software
    assign wflag_set = {parallel_port_set, conversion_done_set,
                        sync_serial_set, capture_compare_set};
    assign wflag_val = {pwdata[pif_pkg::BIT_PARALLEL_PORT],
                        pwdata[pif_pkg::BIT_CONVERSION_DONE],
                        pwdata[pif_pkg::BIT_SYNC_SERIAL],
                        pwdata[pif_pkg::BIT_CAPTURE_COMPARE]};
    assign wflag_load = {pif_pkg::WFLAG_W{wr_flags}};

    pif_sticky_bits #(
        .W(pif_pkg::WFLAG_W),
        .RESET_VAL(pif_pkg::WFLAG_RESET)
    ) u_flags (
        .clk(pclk),
        .rst_n(presetn),
        .set(wflag_set),
        .load(wflag_load),
        .load_val(wflag_val),
        .q(wflag_q)
    );

    // ==========================================================
    // buffer state bits, read only
    // follows receive buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full_reg <= 1'b0;
        end else begin
            rx_full_reg <= rx_buf_full;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_empty_reg <= 1'b0;
        end else begin
            tx_empty_reg <= tx_buf_empty;
        end
    end

    assign receive_full_rise = rx_buf_full && !rx_full_reg;
    assign transmit_empty_rise = tx_buf_empty && !tx_empty_reg;

    // ==========================================================
    // flag bank assembly; bits 1 and 0 live outside this bank
    always_comb begin
        flags_now = 8'h00;
        flags_now[pif_pkg::BIT_PARALLEL_PORT] = wflag_q[3];
        flags_now[pif_pkg::BIT_CONVERSION_DONE] = wflag_q[2];
        flags_now[pif_pkg::BIT_RECEIVE_FULL] = rx_full_reg;
        flags_now[pif_pkg::BIT_TRANSMIT_EMPTY] = tx_empty_reg;
        flags_now[pif_pkg::BIT_SYNC_SERIAL] = wflag_q[1];
        flags_now[pif_pkg::BIT_CAPTURE_COMPARE] = wflag_q[0];
    end

    assign peripheral_irq_flags_a = flags_now;

    // ==========================================================
    // interrupt status: sticky events, write one to clear
    always_comb begin
        ev_set = pif_pkg::EV_RESET;
        ev_set[pif_pkg::EV_PARALLEL_PORT] = parallel_port_set;
        ev_set[pif_pkg::EV_CONVERSION_DONE] = conversion_done_set;
        ev_set[pif_pkg::EV_RECEIVE_FULL] = receive_full_rise;
        ev_set[pif_pkg::EV_TRANSMIT_EMPTY] = transmit_empty_rise;
        ev_set[pif_pkg::EV_SYNC_SERIAL] = sync_serial_set;
        ev_set[pif_pkg::EV_CAPTURE_COMPARE] = capture_compare_set;
    end

    assign ev_clear = wr_status ? pwdata[pif_pkg::EV_W-1:0] : pif_pkg::EV_RESET;

    pif_sticky_bits #(
        .W(pif_pkg::EV_W),
        .RESET_VAL(pif_pkg::EV_RESET)
    ) u_status (
        .clk(pclk),
        .rst_n(presetn),
        .set(ev_set),
        .load(ev_clear),
        .load_val(pif_pkg::EV_RESET),
        .q(status_q)
    );

    // ==========================================================
    // interrupt output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_q & mask_reg);
        end
    end

    assign irq = irq_reg;

endmodule

`default_nettype wire

//--- verif/pif_flag_bank_monitor.sv
// Purpose: port assertions for the flag bank
// Assumes: apb writes land where psel, penable and pready are high
// Notes: mode registers are shadowed from observed writes

`timescale 1ns/1ps
`default_nettype none

module pif_flag_bank_monitor (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic pready, // apb ready
    input wire logic psp_access_done, // event
    input wire logic adc_conv_done, // event
    input wire logic rx_buf_full, // level
    input wire logic tx_buf_empty, // level
    input wire logic spi_xfer_done, // event
    input wire logic i2c_byte_done, // event
    input wire logic i2c_seq_done, // event
    input wire logic i2c_bus_start, // event
    input wire logic i2c_bus_stop, // event
    input wire logic i2c_port_idle, // level
    input wire logic ccp_capture_event, // event
    input wire logic ccp_compare_match, // event
    input wire logic [7:0] peripheral_irq_flags_a // flags
);
    logic [7:0] f;
    logic fwr;
    logic [1:0] ccp_m;
    logic [2:0] ssp_c;
    logic ccp_set;
    logic ssp_ok;
    assign f = peripheral_irq_flags_a;
    assign fwr = psel && penable && pready && pwrite && paddr == pif_pkg::ADDR_FLAGS;
    assign ccp_set = (ccp_capture_event && ccp_m == 2'b01) || (ccp_compare_match && ccp_m == 2'b10);
    assign ssp_ok = fwr || (spi_xfer_done && ssp_c[1:0] == 2'b01)
        || ((i2c_byte_done || i2c_seq_done) && ssp_c[1:0] == 2'b10)
        || ((i2c_bus_start || i2c_bus_stop) && i2c_port_idle && ssp_c == 3'b110);

    // shadow of mode registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccp_m <= 2'h0;
            ssp_c <= 3'h0;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == pif_pkg::ADDR_CCP_MODE) ccp_m <= pwdata[1:0];
            if (paddr == pif_pkg::ADDR_SSP_CTRL) ssp_c <= pwdata[2:0];
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_bus_idle;
        (i2c_bus_start || i2c_bus_stop) ##0 (i2c_port_idle && ssp_c == 3'b110);
    endsequence

    AST_PAR_SET: assert property (psp_access_done |=> f[7])
        else $error("parallel flag not set");
    AST_ADC_SET: assert property (adc_conv_done |=> f[6])
        else $error("conversion flag not set");
    AST_RX_FOLLOW: assert property (1'b1 |=> f[5] == $past(rx_buf_full))
        else $error("receive flag not following buffer");
    AST_TX_FOLLOW: assert property (1'b1 |=> f[4] == $past(tx_buf_empty))
        else $error("transmit flag not following buffer");
    AST_SPI_SET: assert property (spi_xfer_done && ssp_c[1:0] == 2'b01 |=> f[3])
        else $error("spi event lost");
    AST_I2C_OWN: assert property ((i2c_byte_done || i2c_seq_done) && ssp_c[1:0] == 2'b10 |=> f[3])
        else $error("i2c own event lost");
    AST_I2C_BUS: assert property (s_bus_idle |=> f[3])
        else $error("i2c bus event lost");
    AST_SSP_ONLY: assert property ($rose(f[3]) |-> $past(ssp_ok))
        else $error("sync serial flag set without cause");
    AST_STICKY: assert property (|($past(f) & ~f & 8'hCC) |-> $past(fwr))
        else $error("flag cleared by hardware");
    AST_CCP_SET: assert property (ccp_set |=> f[2])
        else $error("capture/compare flag not set");
    AST_CCP_ONLY: assert property ($rose(f[2]) |-> $past(ccp_set) || $past(fwr))
        else $error("capture/compare flag set without cause");
    AST_LOW_ZERO: assert property (f[1:0] == 2'h0)
        else $error("low flag bits not zero");
endmodule

bind pif_flag_bank pif_flag_bank_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .psp_access_done, .adc_conv_done, .rx_buf_full, .tx_buf_empty,
    .spi_xfer_done, .i2c_byte_done, .i2c_seq_done, .i2c_bus_start, .i2c_bus_stop,
    .i2c_port_idle, .ccp_capture_event, .ccp_compare_match, .peripheral_irq_flags_a);

`default_nettype wire

//--- verif/pif_flag_bank_tb_top.sv
// Purpose: self-checking bench for the flag bank
// Assumes: apb slave answers with pready, events are one-cycle pulses
// Notes: event inputs driven from one vector ev

`timescale 1ns/1ps
`default_nettype none

module pif_flag_bank_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [8:0] ev = 9'h000;
    logic rx_buf_full = 1'b0;
    logic tx_buf_empty = 1'b0;
    logic i2c_port_idle = 1'b0;
    logic [7:0] flags;
    logic irq;
    logic [31:0] r;
    logic e;
    int n_mismatch = 0;
    int check_count = 0;

    always #20 pclk = ~pclk;

    pif_flag_bank i_pif_flag_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .psp_access_done(ev[0]), .adc_conv_done(ev[1]),
        .rx_buf_full, .tx_buf_empty, .spi_xfer_done(ev[2]), .i2c_byte_done(ev[3]),
        .i2c_seq_done(ev[4]), .i2c_bus_start(ev[5]), .i2c_bus_stop(ev[6]), .i2c_port_idle,
        .ccp_capture_event(ev[7]), .ccp_compare_match(ev[8]),
        .peripheral_irq_flags_a(flags), .irq);

    // ==========================================================
    // bus and compare helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hung transfer
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        // access phase lasts exactly one cycle
        chk(32'(n), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(r, x);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev <= 9'h000;
    endtask

    task automatic ev_case(input int i, input int b, input logic x);
        wr(pif_pkg::ADDR_FLAGS, 32'h0);
        pulse(i);
        rd(pif_pkg::ADDR_FLAGS, 32'(x) << b);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        for (int a = 0; a < 5; a++) begin
            rd(8'(a * 4), 32'h0);
            chk({31'h0, e}, 32'h0);
        end
        wr(8'h14, 32'hFF);
        chk({31'h0, e}, 32'h1);
    endtask

    task automatic t_sticky;
        pulse(0);
        pulse(1);
        repeat (10) @(posedge pclk);
        rd(pif_pkg::ADDR_FLAGS, 32'hC0);
        rd(pif_pkg::ADDR_STATUS, 32'h03);
        chk({31'h0, irq}, 32'h0);
        wr(pif_pkg::ADDR_MASK, 32'h02);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(pif_pkg::ADDR_STATUS, 32'h02);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(pif_pkg::ADDR_FLAGS, 32'h0);
        rd(pif_pkg::ADDR_FLAGS, 32'h0);
    endtask

    task automatic t_buf;
        rx_buf_full <= 1'b1;
        tx_buf_empty <= 1'b1;
        wr(pif_pkg::ADDR_FLAGS, 32'hFF);
        rd(pif_pkg::ADDR_FLAGS, 32'hFC);
        wr(pif_pkg::ADDR_FLAGS, 32'h0);
        rx_buf_full <= 1'b0;
        rd(pif_pkg::ADDR_FLAGS, 32'h10);
        tx_buf_empty <= 1'b0;
        rx_buf_full <= 1'b1;
        rd(pif_pkg::ADDR_FLAGS, 32'h20);
        rx_buf_full <= 1'b0;
        rd(pif_pkg::ADDR_STATUS, 32'h0D);
        wr(pif_pkg::ADDR_STATUS, 32'h3F);
    endtask

    task automatic t_ssp;
        logic x;
        i2c_port_idle <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(pif_pkg::ADDR_SSP_CTRL, 32'(c));
            for (int i = 2; i < 7; i++) begin
                x = (c[1:0] == 2'b01 && i == 2) || (c[1:0] == 2'b10 && (i == 3 || i == 4))
                    || (c[2:0] == 3'b110 && i > 4);
                ev_case(i, 3, x);
            end
        end
        wr(pif_pkg::ADDR_SSP_CTRL, 32'h6);
        i2c_port_idle <= 1'b0;
        ev_case(5, 3, 1'b0);
        ev_case(3, 3, 1'b1);
        repeat (30) @(posedge pclk);
        rd(pif_pkg::ADDR_FLAGS, 32'h08);
    endtask

    task automatic t_ccp;
        for (int m = 0; m < 4; m++) begin
            wr(pif_pkg::ADDR_CCP_MODE, 32'(m));
            ev_case(7, 2, m == 1);
            ev_case(8, 2, m == 2);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sticky();
        t_buf();
        t_ssp();
        t_ccp();
        finish_test();
    end

    // run needs about 550 cycles; allow about nine times that
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule

`default_nettype wire
